// ===== bench/csi2_video_test_pattern_generator_tb.sv
// Testbench: line contents and frame timing of the generator.
// Assumes a 250 MHz clock; settings change only while stopped.
`timescale 1ns/1ps
`default_nettype none
module csi2_video_test_pattern_generator_tb;
  logic clk = 0, reset_n = 0, en = 0, fixed = 0, slow = 0;
  logic [1:0] sel = 2'h3, vc = 2'h0;
  logic [5:0] dt = 6'h24;
  logic [3:0] blen = 4'h2;
  logic [7:0] vfp = 8'h1;
  logic [15:0] bar = 16'h6;
  logic [127:0] blk = 128'h0f0e0d0c0b0a09080706050403020100;
  logic [7:0] bars [8] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80};
  int errors = 0, check_count = 0, cyc = 0;
  wire s, st, dv, dl, fa;
  wire [7:0] hd, db;
  wire [15:0] wc;
  always #2 clk = ~clk;
  pgen_top dut (.clk(clk), .reset_n(reset_n), .pattern_gen_control_en(en), .fixed_mode(fixed),
    .bar_count_sel(sel), .slow_rate(slow), .line_length_bytes(16'h34), .bar_size_bytes(bar),
    .data_type(dt), .virtual_channel(vc), .active_lines_per_frame(16'h2),
    .total_lines_per_frame(16'h7), .line_period_count(16'h20), .vertical_back_porch_lines(8'h1),
    .vertical_front_porch_lines(vfp), .block_len_m1(blen), .block_bytes(blk),
    .pkt_short_r(s), .pkt_start_r(st), .pkt_header_r(hd), .pkt_word_count_r(wc),
    .data_valid_r(dv), .data_byte_r(db), .data_last_r(dl), .frame_active_r(fa));
  pgen_sink sink (.clk(clk), .pkt_short_r(s), .pkt_header_r(hd), .pkt_start_r(st),
    .data_valid_r(dv), .data_byte_r(db));
  task automatic cmp(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  function automatic logic [7:0] exp_b(input int i);
    int k;
    logic [7:0] v;
    k = i / bar;
    if (k > (1 << sel) - 1) k = (1 << sel) - 1;
    v = blk[(i % (blen + 1)) * 8 +: 8];
    exp_b = fixed ? (k[0] ? ~v : v) : bars[k];
  endfunction
  // Stop first: while running, enable is only looked at on line ends
  task automatic setup(input bit f, input int n, input bit sl);
    @(negedge clk);
    en = 0;
    repeat (400) @(negedge clk);
    fixed = f;
    sel = n[1:0];
    slow = sl;
    vfp = 8'(1 + sl);
    dt = 6'h24 + 6'(n);
    vc = n[1:0];
    bar = 16'(((52 / 3) >> n) * 3);
    en = 1;
  endtask
  task automatic chk_line();
    int t;
    t = sink.n_ln;
    while (sink.n_ln == t) @(negedge clk);
    while (dl !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmp(sink.idx == 52, "line length");
    for (int i = 0; i < 52; i++) cmp(sink.line_q[i] === exp_b(i), "line byte");
  endtask
  task automatic t_frame(input bit sl);
    int f, l, e;
    setup(0, 3, sl);
    f = sink.n_fs;
    while (sink.n_fs == f) @(negedge clk);
    l = sink.n_ln;
    e = sink.n_fe;
    f = sink.n_fs;
    while (sink.n_fs == f) @(negedge clk);
    cmp(sink.n_ln - l == 2, "active lines");
    cmp(sink.n_fe - e == 1, "frame end count");
    cmp(sink.t1 - sink.t0 == 7 * 32 * (sl ? 20 : 10), "frame period");
    cmp(sink.t_fe - sink.t0 == (4 + vfp) * 32 * (sl ? 20 : 10), "end line");
  endtask
  task automatic results();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1;
    for (int n = 0; n < 4; n++) begin
      setup(0, n, 0);
      chk_line();
    end
    setup(1, 3, 0);
    chk_line();
    t_frame(0);
    t_frame(1);
    results();
  end
endmodule // csi2_video_test_pattern_generator_tb
`default_nettype wire

// ===== bench/pgen_chk_sva.sv
// Port assertions for the pattern generator.
// Assumes binding onto pgen_top; all outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module pgen_chk #(
  parameter LW = 16
) (
  input wire clk,
  input wire reset_n,
  input wire fixed_mode,
  input wire [5:0] data_type,
  input wire [1:0] virtual_channel,
  input wire [LW-1:0] line_length_bytes,
  input wire pkt_short_r,
  input wire pkt_start_r,
  input wire [7:0] pkt_header_r,
  input wire [LW-1:0] pkt_word_count_r,
  input wire data_valid_r,
  input wire [7:0] data_byte_r,
  input wire data_last_r,
  input wire frame_active_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_first;
    data_valid_r && (fixed_mode || data_byte_r == 8'haa);
  endsequence
  a_start_first_bar: assert property (pkt_start_r |=> s_first)
    else $error("line did not open with first bar");
  a_start_word_count: assert property (pkt_start_r |-> pkt_word_count_r == line_length_bytes)
    else $error("word count differs from line length");
  a_start_header: assert property (pkt_start_r |-> pkt_header_r == {virtual_channel, data_type})
    else $error("long header differs");
  a_short_header: assert property (pkt_short_r |-> pkt_header_r[5:0] <= 6'h01 && pkt_header_r[7:6] == virtual_channel)
    else $error("short header differs");
  a_short_alone: assert property (pkt_short_r |-> !data_valid_r && !pkt_start_r)
    else $error("short packet overlaps line");
  a_last_valid: assert property (data_last_r |-> data_valid_r)
    else $error("last flag without byte");
  a_run_bytes: assert property (data_valid_r && !data_last_r |=> data_valid_r)
    else $error("gap inside line");
  a_data_in_frame: assert property (data_valid_r |-> frame_active_r)
    else $error("byte outside frame");
endmodule // pgen_chk
bind pgen_top pgen_chk #(.LW(LW)) u_chk (
  .clk(clk),
  .reset_n(reset_n),
  .fixed_mode(fixed_mode),
  .data_type(data_type),
  .virtual_channel(virtual_channel),
  .line_length_bytes(line_length_bytes),
  .pkt_short_r(pkt_short_r),
  .pkt_start_r(pkt_start_r),
  .pkt_header_r(pkt_header_r),
  .pkt_word_count_r(pkt_word_count_r),
  .data_valid_r(data_valid_r),
  .data_byte_r(data_byte_r),
  .data_last_r(data_last_r),
  .frame_active_r(frame_active_r)
);
`default_nettype wire

// ===== bench/pgen_sink.sv
// Far-side model: CSI-2 sink capturing the generator's packets.
// Assumes single-cycle strobes sampled on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module pgen_sink (
  input wire clk,
  input wire pkt_short_r,
  input wire [7:0] pkt_header_r,
  input wire pkt_start_r,
  input wire data_valid_r,
  input wire [7:0] data_byte_r
);
  logic [7:0] line_q [0:63];
  int idx = 0, n_fs = 0, n_fe = 0, n_ln = 0;
  time t0 = 0, t1 = 0, t_fe = 0;
  // Never stalls: packets arrive formatted, unbuffered
  always @(posedge clk) begin
    if (pkt_start_r) begin
      idx = 0;
      n_ln++;
    end
    if (data_valid_r && idx < 64) begin
      line_q[idx] = data_byte_r;
      idx++;
    end
    if (pkt_short_r && pkt_header_r[5:0] == 6'h00) begin
      n_fs++;
      t0 = t1;
      t1 = $time;
    end
    if (pkt_short_r && pkt_header_r[5:0] == 6'h01) begin
      n_fe++;
      t_fe = $time;
    end
  end
endmodule // pgen_sink
`default_nettype wire

// ===== rtl/pgen_map.vh
// Constants for the CSI-2 test pattern generator.
// Assumes inclusion by pgen_top.v only.
`ifndef PGEN_MAP_VH
`define PGEN_MAP_VH
`define PGEN_BAR0 8'haa
`define PGEN_BAR1 8'h33
`define PGEN_BAR2 8'hf0
`define PGEN_BAR3 8'h7f
`define PGEN_BAR4 8'h55
`define PGEN_BAR5 8'hcc
`define PGEN_BAR6 8'h0f
`define PGEN_BAR7 8'h80
`define PGEN_DT_FS 6'h00
`define PGEN_DT_FE 6'h01
`define PGEN_UNIT_NS 10
`define PGEN_UNIT_SLOW_NS 20
`define PGEN_CLK_NS 4
`define PATTERN_GEN_CONTROL_EN 0
`define PATTERN_GEN_CONTROL_FIXED 1
`define PATTERN_GEN_CONTROL_BARS_LSB 4
`endif

// ===== rtl/pgen_top.v
// CSI-2 test pattern generator, one instance per transmit port.
// Assumes clk is the transmit clock; settings are static while enabled.
`include "pgen_map.vh"
`timescale 1ns/1ps
`default_nettype none
module pgen_top #(
  parameter LW = 16,
  parameter NBLK = 16
) (
  input wire clk,
  input wire reset_n,
  input wire pattern_gen_control_en,
  input wire fixed_mode,
  input wire [1:0] bar_count_sel,
  input wire slow_rate,
  input wire [LW-1:0] line_length_bytes,
  input wire [LW-1:0] bar_size_bytes,
  input wire [5:0] data_type,
  input wire [1:0] virtual_channel,
  input wire [LW-1:0] active_lines_per_frame,
  input wire [LW-1:0] total_lines_per_frame,
  input wire [LW-1:0] line_period_count,
  input wire [7:0] vertical_back_porch_lines,
  input wire [7:0] vertical_front_porch_lines,
  input wire [3:0] block_len_m1,
  input wire [8*NBLK-1:0] block_bytes,
  output reg pkt_short_r,
  output reg pkt_start_r,
  output reg [7:0] pkt_header_r,
  output reg [LW-1:0] pkt_word_count_r,
  output reg data_valid_r,
  output reg [7:0] data_byte_r,
  output reg data_last_r,
  output reg frame_active_r
);
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_LINE = 3'b010;
  localparam [2:0] S_WAIT = 3'b100;
  localparam integer CLK_NS_I = `PGEN_CLK_NS;
  localparam integer UNIT_NS_I = `PGEN_UNIT_NS;
  localparam integer SLOW_NS_I = `PGEN_UNIT_SLOW_NS;
  localparam [4:0] CLK_STEP = CLK_NS_I[4:0];
  localparam [4:0] UNIT_FAST = UNIT_NS_I[4:0];
  localparam [4:0] UNIT_SLOW = SLOW_NS_I[4:0];

  // Reference bar bytes in line order
  function [7:0] bar_byte;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: bar_byte = `PGEN_BAR0;
        3'h1: bar_byte = `PGEN_BAR1;
        3'h2: bar_byte = `PGEN_BAR2;
        3'h3: bar_byte = `PGEN_BAR3;
        3'h4: bar_byte = `PGEN_BAR4;
        3'h5: bar_byte = `PGEN_BAR5;
        3'h6: bar_byte = `PGEN_BAR6;
        default: bar_byte = `PGEN_BAR7;
      endcase
    end
  endfunction

  // Per-port state only, nothing shared between instances
  reg [2:0] state_r;
  reg [LW-1:0] line_r;
  reg [LW-1:0] period_r;
  reg [4:0] acc_r;
  reg [LW-1:0] byte_r;
  reg [LW-1:0] bar_cnt_r;
  reg [2:0] bar_idx_r;
  reg [3:0] blk_r;
  reg sent_r;

  wire [2:0] last_bar = (3'h1 << bar_count_sel) - 3'h1;
  // Line plan: 0 start, back porch, active, front porch, end, padding
  wire [LW-1:0] vbp_end = {{(LW-8){1'b0}}, vertical_back_porch_lines} + 1'b1;
  wire [LW-1:0] act_end = vbp_end + active_lines_per_frame;
  wire [LW-1:0] fe_line = act_end + {{(LW-8){1'b0}}, vertical_front_porch_lines};
  wire line_is_active = line_r >= vbp_end && line_r < act_end;
  // Fixed block byte, inverted on odd bars
  wire [7:0] blk_byte = block_bytes[blk_r*8 +: 8];
  wire [7:0] fixed_byte = bar_idx_r[0] ? ~blk_byte : blk_byte;
  wire [7:0] hdr = {virtual_channel, data_type};
  // Remainder in ns, so a 10 ns unit averages 2.5 clocks with no drift
  wire [4:0] unit_ns = slow_rate ? UNIT_SLOW : UNIT_FAST;
  wire [5:0] acc_sum = {1'b0, acc_r} + {1'b0, CLK_STEP};
  wire [5:0] acc_left = acc_sum - {1'b0, unit_ns};
  wire tick = acc_sum >= {1'b0, unit_ns};
  // A line that outlasts its period misses the boundary; keep period long
  wire period_done = tick && period_r == 16'h0;
  wire line_done = byte_r == line_length_bytes - 1'b1;

  // Unit timebase: remainder carried in ns, line count reloads at each boundary
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= 5'h0;
      period_r <= 16'h0;
    end else if (state_r == S_IDLE) begin
      // Primed as if a boundary fell now, so line 0 is full length
      acc_r <= 5'h0;
      period_r <= line_period_count - 1'b1;
    end else begin
      acc_r <= tick ? acc_left[4:0] : acc_sum[4:0];
      if (tick)
        period_r <= period_done ? line_period_count - 1'b1 : period_r - 1'b1;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      line_r <= 16'h0;
      byte_r <= 16'h0;
      bar_cnt_r <= 16'h0;
      bar_idx_r <= 3'h0;
      blk_r <= 4'h0;
      sent_r <= 1'b0;
      pkt_short_r <= 1'b0;
      pkt_start_r <= 1'b0;
      pkt_header_r <= 8'h0;
      pkt_word_count_r <= 16'h0;
      data_valid_r <= 1'b0;
      data_byte_r <= 8'h0;
      data_last_r <= 1'b0;
      frame_active_r <= 1'b0;
    end else begin
      // Strobes last one cycle; header and word count hold
      pkt_short_r <= 1'b0;
      pkt_start_r <= 1'b0;
      data_valid_r <= 1'b0;
      data_last_r <= 1'b0;
      case (state_r)
        // Idle emits nothing; the timebase waits primed for line 0
        S_IDLE: begin
          if (pattern_gen_control_en) begin
            state_r <= S_LINE;
            line_r <= 16'h0;
            sent_r <= 1'b0;
          end
        end
        S_LINE: begin
          // Line 0 carries frame start, line fe_line frame end
          if (line_r == 16'h0) begin
            pkt_short_r <= 1'b1;
            pkt_header_r <= {virtual_channel, `PGEN_DT_FS};
            pkt_word_count_r <= 16'h0;
            frame_active_r <= 1'b1;
            state_r <= S_WAIT;
          end else if (line_r == fe_line) begin
            pkt_short_r <= 1'b1;
            pkt_header_r <= {virtual_channel, `PGEN_DT_FE};
            pkt_word_count_r <= 16'h0;
            frame_active_r <= 1'b0;
            state_r <= S_WAIT;
          end else if (line_is_active) begin
            if (!sent_r) begin
              pkt_start_r <= 1'b1;
              pkt_header_r <= hdr;
              pkt_word_count_r <= line_length_bytes;
              sent_r <= 1'b1;
              byte_r <= 16'h0;
              bar_cnt_r <= 16'h0;
              bar_idx_r <= 3'h0;
              blk_r <= 4'h0;
            end else begin
              data_valid_r <= 1'b1;
              data_byte_r <= fixed_mode ? fixed_byte : bar_byte(bar_idx_r);
              data_last_r <= line_done;
              byte_r <= byte_r + 1'b1;
              blk_r <= blk_r == block_len_m1 ? 4'h0 : blk_r + 4'h1;
              // Last bar holds its value to line end
              if (bar_cnt_r == bar_size_bytes - 1'b1 && bar_idx_r != last_bar) begin
                bar_cnt_r <= 16'h0;
                bar_idx_r <= bar_idx_r + 3'h1;
              end else begin
                bar_cnt_r <= bar_cnt_r + 1'b1;
              end
              if (line_done)
                state_r <= S_WAIT;
            end
          end else begin
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (period_done) begin
            sent_r <= 1'b0;
            // Wrap at total count; padding lines emit nothing
            if (line_r >= total_lines_per_frame - 1'b1 || line_r == 16'hffff)
              line_r <= 16'h0;
            else
              line_r <= line_r + 1'b1;
            state_r <= pattern_gen_control_en ? S_LINE : S_IDLE;
            if (!pattern_gen_control_en)
              frame_active_r <= 1'b0;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // pgen_top
`default_nettype wire
